// [rtl/atfsc_defines.svh]
// offsets, field positions, reset values and the diagnostic code of the task file block
`ifndef ATFSC_DEFINES_SVH
`define ATFSC_DEFINES_SVH
`define ATFSC_OFS_CYL_HIGH 4'h5
`define ATFSC_OFS_UNIT_HEAD 4'h6
`define ATFSC_OFS_STATUS 4'h7
`define ATFSC_OFS_SHADOW 4'hE
`define ATFSC_OFS_DEV_CTRL 4'hE
`define ATFSC_OFS_UNIT_ADDR 4'hF
`define ATFSC_DH_LBA_BIT 6
`define ATFSC_DH_UNIT_BIT 4
`define ATFSC_DH_ONES 8'hA0
`define ATFSC_DC_SRST_BIT 2
`define ATFSC_DC_IEN_N_BIT 1
`define ATFSC_ST_BUSY 7
`define ATFSC_ST_READY 6
`define ATFSC_ST_FAULT 5
`define ATFSC_ST_SEEK 4
`define ATFSC_ST_XFER 3
`define ATFSC_ST_FIXED 2
`define ATFSC_ST_INDEX 1
`define ATFSC_ST_ERR 0
`define ATFSC_RST_CYL_HIGH 8'h00
`define ATFSC_RST_UNIT_HEAD 8'hA0
`define ATFSC_RST_STATUS 8'h00
`define ATFSC_DIAG_CODE 8'h01
`endif

// [rtl/atfsc_pkg.sv]
// types shared by the task file block
package atfsc_pkg;
  // one host access to the task file
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } atfsc_req_t;
  // events from the card's command engine
  typedef struct packed {
    logic cmd_start;
    logic cmd_done;
    logic ready;
    logic xfer_set;
    logic fault;
    logic fixed;
    logic err;
    logic write_active;
    logic irq_event;
  } atfsc_evt_t;
  typedef enum logic [2:0] {
    ATFSC_ST_RUN = 3'b001,
    ATFSC_ST_SRST = 3'b010,
    ATFSC_ST_RECOVER = 3'b100
  } atfsc_state_t;
endpackage

// [rtl/atfsc_reg8.sv]
// one 8-bit host register with write strobe and fixed reset value
`timescale 1ns/1ps
`default_nettype none
module atfsc_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] FORCE_ONE = 8'h00
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  logic [7:0] q_q;
  // forced-one bits ignore what is written
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_q <= RESET_VAL;
    end else if (we) begin
      q_q <= wdata | FORCE_ONE;
    end
  end
  assign q = q_q;
endmodule
`default_nettype wire

// [rtl/atfsc_top.sv]
// upper task file: cylinder high, drive/head, status, device control, drive address
`timescale 1ns/1ps
`default_nettype none
`include "atfsc_defines.svh"
module atfsc_top (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // host task file access, one cycle strobes
  input wire atfsc_pkg::atfsc_req_t I_REQ,
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  // card engine side
  input wire atfsc_pkg::atfsc_evt_t I_EVT,
  input wire logic I_UNIT_NUM,
  input wire logic [7:0] I_SECTOR_NUM,
  input wire logic [7:0] I_CYL_LOW,
  output logic [27:0] O_BLOCK_ADDR,
  output logic O_LBA_MODE,
  output logic O_UNIT_SELECTED,
  output logic O_SOFT_RESET,
  output logic O_BUSY,
  output logic O_INT_ENABLE,
  output logic O_INTERRUPT_REQUEST_N
);
  import atfsc_pkg::*;

  // host visible registers
  logic [7:0] cyl_high;
  logic [7:0] unit_head;
  logic [1:0] dev_ctrl_q;
  // status and interrupt state
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic irq_pend_q;
  logic wr_active_q;
  // soft reset sequencer
  atfsc_state_t state_q;
  atfsc_state_t state_d;
  // registered copies that drive the pins
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [27:0] addr_q;
  logic lba_q;
  logic unit_sel_q;
  logic busy_q;
  logic int_en_q;
  logic irq_n_q;

  // address decode
  wire wr_cyl = I_REQ.wr && (I_REQ.addr == `ATFSC_OFS_CYL_HIGH);
  wire wr_dh = I_REQ.wr && (I_REQ.addr == `ATFSC_OFS_UNIT_HEAD);
  // control is taken even while busy
  wire wr_dc = I_REQ.wr && (I_REQ.addr == `ATFSC_OFS_DEV_CTRL);
  wire rd_status = I_REQ.rd && (I_REQ.addr == `ATFSC_OFS_STATUS);
  wire rd_shadow = I_REQ.rd && (I_REQ.addr == `ATFSC_OFS_SHADOW);
  wire rd_daddr = I_REQ.rd && (I_REQ.addr == `ATFSC_OFS_UNIT_ADDR);
  wire rd_cyl = I_REQ.rd && (I_REQ.addr == `ATFSC_OFS_CYL_HIGH);
  wire rd_dh = I_REQ.rd && (I_REQ.addr == `ATFSC_OFS_UNIT_HEAD);
  wire srst_req = dev_ctrl_q[1];
  // reset acts from the cycle after the write, not one edge later with the sequencer
  wire in_reset = srst_req || (state_q == ATFSC_ST_SRST);

  // host-writable address registers; block addressing depends on these
  atfsc_reg8 #(
    .RESET_VAL(`ATFSC_RST_CYL_HIGH),
    .FORCE_ONE(8'h00)
  ) u_cyl_high (
    .clk(I_CLK),
    .nrst(I_NRST),
    .we(wr_cyl && !in_reset),
    .wdata(I_REQ.wdata),
    .q(cyl_high)
  );

  // bits 7 and 5 forced high on every write
  atfsc_reg8 #(
    .RESET_VAL(`ATFSC_RST_UNIT_HEAD),
    .FORCE_ONE(`ATFSC_DH_ONES)
  ) u_unit_head (
    .clk(I_CLK),
    .nrst(I_NRST),
    .we(wr_dh && !in_reset),
    .wdata(I_REQ.wdata),
    .q(unit_head)
  );

  // decoded address fields
  wire lba_sel = unit_head[`ATFSC_DH_LBA_BIT];
  wire unit_bit = unit_head[`ATFSC_DH_UNIT_BIT];
  // compared against the card number set by configuration
  wire unit_match = (unit_bit == I_UNIT_NUM);
  // head nibble doubles as block address 27..24
  wire [27:0] addr_d = {unit_head[3:0], cyl_high, I_CYL_LOW, I_SECTOR_NUM};

  // soft reset sequencing; stays in reset while bit is held
  always_comb begin
    state_d = state_q;
    case (state_q)
      ATFSC_ST_RUN: begin
        if (srst_req) begin
          state_d = ATFSC_ST_SRST;
        end
      end
      ATFSC_ST_SRST: begin
        if (!srst_req) begin
          state_d = ATFSC_ST_RECOVER;
        end
      end
      ATFSC_ST_RECOVER: begin
        state_d = srst_req ? ATFSC_ST_SRST : ATFSC_ST_RUN;
      end
      default: begin
        state_d = ATFSC_ST_SRST;
      end
    endcase
  end

  // status byte next value
  always_comb begin
    status_d = status_q;
    if (in_reset) begin
      // clears status while held, except busy, which is set
      status_d = `ATFSC_RST_STATUS;
      status_d[`ATFSC_ST_BUSY] = 1'b1;
    end else begin
      if (I_EVT.cmd_start) begin
        // new command clears request and error
        status_d[`ATFSC_ST_XFER] = 1'b0;
        status_d[`ATFSC_ST_ERR] = 1'b0;
        status_d[`ATFSC_ST_FIXED] = 1'b0;
        status_d[`ATFSC_ST_FAULT] = 1'b0;
        // host locked out of command and buffer
        status_d[`ATFSC_ST_BUSY] = 1'b1;
      end
      if (I_EVT.cmd_done || state_q == ATFSC_ST_RECOVER) begin
        status_d[`ATFSC_ST_BUSY] = 1'b0;
      end
      // ready stays low until engine reports it
      status_d[`ATFSC_ST_READY] = I_EVT.ready;
      status_d[`ATFSC_ST_SEEK] = I_EVT.ready;
      // sets come after clears so a same-cycle event wins
      if (I_EVT.xfer_set) begin
        status_d[`ATFSC_ST_XFER] = 1'b1;
      end
      // fault, fixed-error and error stay set until the next command or a soft reset
      if (I_EVT.fault) begin
        status_d[`ATFSC_ST_FAULT] = 1'b1;
      end
      if (I_EVT.fixed) begin
        status_d[`ATFSC_ST_FIXED] = 1'b1; // sticky only, no abort
      end
      if (I_EVT.err) begin
        status_d[`ATFSC_ST_ERR] = 1'b1;
      end
    end
    status_d[`ATFSC_ST_INDEX] = 1'b0;
  end

  // interrupt pending: an engine event beats a clearing status read
  wire irq_pend_d = I_EVT.irq_event || (irq_pend_q && !rd_status && !in_reset);

  // read mux; writes to read-only offsets fall through untouched
  // drive address byte: bit 7 reads one, unit selects are active low
  wire [7:0] daddr_val = {1'b1, !wr_active_q, ~unit_head[3:0],
    !(unit_match && unit_bit), !(unit_match && !unit_bit)};
  // unmapped offsets read as zero
  wire [7:0] rdata_d = (rd_status || rd_shadow) ? status_q :
    rd_daddr ? daddr_val :
    rd_cyl ? cyl_high :
    rd_dh ? unit_head : 8'h00;

  // device control: only bits 2 and 1 stored, the rest ignored
  wire [1:0] dev_ctrl_d = wr_dc ?
    {I_REQ.wdata[`ATFSC_DC_SRST_BIT], I_REQ.wdata[`ATFSC_DC_IEN_N_BIT]} : dev_ctrl_q;
  // next values of the pin flops, named so each always_ff stays one line deep
  wire int_en_d = !dev_ctrl_d[0];
  // busy taken from the same next value as the status byte, never a cycle late
  wire busy_d = status_d[`ATFSC_ST_BUSY];
  // output gated by the disable bit
  // the mask acts on the pin only; a pending request survives it
  wire irq_n_d = !(irq_pend_d && !dev_ctrl_q[0]);

  // control bits; interrupts enabled at power-on
  // written even while busy, the host needs this path to break a hang
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      dev_ctrl_q <= 2'h0;
    end else begin
      dev_ctrl_q <= dev_ctrl_d;
    end
  end

  // enable pin as its own flop rather than an inverter on the control bit
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      int_en_q <= 1'b1;
    end else begin
      int_en_q <= int_en_d;
    end
  end

  // soft reset sequencer state
  // an illegal code falls back into reset through the default branch
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q <= ATFSC_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // status byte
  // no enable here: every cycle recomputes, so a stale bit cannot linger
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      status_q <= `ATFSC_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt pending
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_pend_q <= 1'b0;
    end else begin
      irq_pend_q <= irq_pend_d;
    end
  end

  // write activity level for the drive address byte
  // plain register, the engine drives it from this same clock
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wr_active_q <= 1'b0;
    end else begin
      wr_active_q <= I_EVT.write_active;
    end
  end

  // read data
  // taken at the request edge, so the byte stands for exactly one cycle
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // read answer strobe, one cycle per read whatever the offset
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= I_REQ.rd;
    end
  end

  // block address
  // follows the lower registers one cycle behind, engine samples it at command
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      addr_q <= 28'h0000000;
    end else begin
      addr_q <= addr_d;
    end
  end

  // addressing mode
  // cylinder/head/sector until the host asks for block addressing
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      lba_q <= 1'b0;
    end else begin
      lba_q <= lba_sel;
    end
  end

  // unit match
  // low only while reset is held; from the first clock after it, follows the unit match
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      unit_sel_q <= 1'b0;
    end else begin
      unit_sel_q <= unit_match;
    end
  end

  // busy pin
  // mirrors status bit 7 in the same cycle as the status byte
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // interrupt pin
  // idle high after reset, so no false request reaches the host
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= irq_n_d;
    end
  end

  // diagnostic code for the error register is loaded by the engine on O_SOFT_RESET
  assign O_RDATA = rdata_q;
  assign O_RVALID = rvalid_q;
  assign O_BLOCK_ADDR = addr_q;
  assign O_LBA_MODE = lba_q;
  assign O_UNIT_SELECTED = unit_sel_q;
  assign O_SOFT_RESET = dev_ctrl_q[1];
  assign O_BUSY = busy_q;
  assign O_INT_ENABLE = int_en_q;
  assign O_INTERRUPT_REQUEST_N = irq_n_q;
endmodule
`default_nettype wire

// [dv/atfsc_host.sv]
// host side model that issues task file accesses
`timescale 1ns/1ps
`default_nettype none
module atfsc_host (
  // bus clock
  input wire logic i_clk,
  // task file access
  output atfsc_pkg::atfsc_req_t o_req,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  import atfsc_pkg::*;
  initial o_req = '0;
  // released lines show the inverse, never a stale copy
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req = '{1'b0, 1'b1, a, (a == 4'hE) ? (d & 8'h06) : d};
    @(negedge i_clk);
    o_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // byte reads only, also of primary status
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge i_clk);
    d = i_rvalid ? i_rdata : 8'hXX;
    o_req = '{1'b0, 1'b0, ~a, 8'hFF};
  endtask
endmodule
`default_nettype wire

// [dv/atfsc_top_chk.sv]
// port checker for the task file block
`timescale 1ns/1ps
`default_nettype none
module atfsc_top_chk (
  // clock, reset and inputs
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire atfsc_pkg::atfsc_req_t I_REQ,
  input wire atfsc_pkg::atfsc_evt_t I_EVT,
  // watched outputs
  input wire logic [7:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic O_LBA_MODE,
  input wire logic O_SOFT_RESET,
  input wire logic O_BUSY,
  input wire logic O_INT_ENABLE,
  input wire logic O_INTERRUPT_REQUEST_N
);
  import atfsc_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // read answers and status fields
  AST_RVALID: assert property (I_REQ.rd |=> O_RVALID)
    else $error("read not answered");
  AST_INDEX: assert property (O_RVALID && $past(I_REQ.addr) == 4'h7 |-> !O_RDATA[1])
    else $error("index bit set");
  AST_ONES: assert property (O_RVALID && $past(I_REQ.addr) == 4'h6
    |-> O_RDATA[7] && O_RDATA[5])
    else $error("fixed ones missing");
  AST_LBA: assert property (O_RVALID && $past(I_REQ.addr) == 4'h6
    |-> O_RDATA[6] == O_LBA_MODE)
    else $error("mode output differs");
  AST_IRQCLR: assert property (I_REQ.rd && I_REQ.addr == 4'h7 && !I_EVT.irq_event
    |=> O_INTERRUPT_REQUEST_N)
    else $error("status read kept interrupt");
  // control writes, interrupt masking and busy
  AST_SRST: assert property (I_REQ.wr && I_REQ.addr == 4'hE
    |=> O_SOFT_RESET == $past(I_REQ.wdata[2]))
    else $error("soft reset not taken");
  AST_IEN: assert property (I_REQ.wr && I_REQ.addr == 4'hE
    |=> O_INT_ENABLE != $past(I_REQ.wdata[1]))
    else $error("enable not taken");
  AST_MASK: assert property (!O_INT_ENABLE && !$past(O_INT_ENABLE)
    |-> O_INTERRUPT_REQUEST_N)
    else $error("masked interrupt seen");
  AST_BUSY: assert property (I_EVT.cmd_start && !I_EVT.cmd_done |=> O_BUSY)
    else $error("busy not set");
  AST_SRBUSY: assert property (O_SOFT_RESET && $past(O_SOFT_RESET) |-> O_BUSY)
    else $error("not busy in soft reset");
endmodule
bind atfsc_top atfsc_top_chk atfsc_top_chk_inst (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_REQ(I_REQ),
  .I_EVT(I_EVT), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_LBA_MODE(O_LBA_MODE),
  .O_SOFT_RESET(O_SOFT_RESET), .O_BUSY(O_BUSY), .O_INT_ENABLE(O_INT_ENABLE),
  .O_INTERRUPT_REQUEST_N(O_INTERRUPT_REQUEST_N));
`default_nettype wire

// [dv/ata_task_file_status_control_tb.sv]
// self-checking bench for the task file block
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_status_control_tb;
  import atfsc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic unit = 1'b0;
  logic [7:0] sec = 8'h00, cyl_lo = 8'h00, rd_d, dh, cy;
  atfsc_req_t req;
  atfsc_evt_t evt = '0;
  logic [7:0] rdata;
  logic [27:0] baddr;
  logic rvalid, lba, usel, srst, busy, ien, irq_n;
  int errors = 0, samples_checked = 0, seed = 76108;
  // bus clock
  always #5 clk = ~clk;
  atfsc_top atfsc_top_inst (.I_CLK(clk), .I_NRST(nrst), .I_REQ(req), .O_RDATA(rdata),
    .O_RVALID(rvalid), .I_EVT(evt), .I_UNIT_NUM(unit), .I_SECTOR_NUM(sec), .I_CYL_LOW(cyl_lo),
    .O_BLOCK_ADDR(baddr), .O_LBA_MODE(lba), .O_UNIT_SELECTED(usel), .O_SOFT_RESET(srst),
    .O_BUSY(busy), .O_INT_ENABLE(ien), .O_INTERRUPT_REQUEST_N(irq_n));
  atfsc_host atfsc_host_inst (.i_clk(clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
  // compare and count
  task automatic chk(input logic [27:0] g, input logic [27:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic rv(input logic [3:0] a, input logic [7:0] e);
    atfsc_host_inst.rd(a, rd_d);
    chk({20'h0, rd_d}, {20'h0, e});
  endtask
  // one-cycle engine pulse, levels kept
  task automatic ev(input int k);
    @(negedge clk);
    evt[k] = 1'b1;
    @(negedge clk);
    evt[k] = 1'b0;
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #50000;
    errors++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    rv(4'h5, 8'h00);
    rv(4'h6, 8'hA0);
    rv(4'h7, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      cy = 8'($random(seed));
      dh = 8'($random(seed));
      unit = 1'($random(seed));
      sec = 8'($random(seed));
      cyl_lo = 8'($random(seed));
      evt.write_active = i[0];
      atfsc_host_inst.wr(4'h5, cy);
      atfsc_host_inst.wr(4'h6, dh);
      rv(4'h5, cy);
      rv(4'h6, dh | 8'hA0);
      rv(4'hF, {1'b1, !i[0], ~dh[3:0], !(dh[4] && unit), !(!dh[4] && !unit)});
      chk(baddr, {dh[3:0], cy, cyl_lo, sec});
      chk({27'h0, lba}, {27'h0, dh[6]});
      chk({27'h0, usel}, {27'h0, dh[4] == unit});
    end
    $display("test address done");
    evt.ready = 1'b1;
    ev(8);
    rv(4'h7, 8'hD0);
    for (int k = 2; k < 6; k++) ev(k);
    ev(7);
    rv(4'h7, 8'h7D);
    rv(4'hE, 8'h7D);
    atfsc_host_inst.wr(4'h7, 8'hFF);
    rv(4'h7, 8'h7D);
    ev(8);
    ev(7);
    rv(4'h7, 8'h50);
    $display("test status done");
    ev(0);
    @(negedge clk);
    chk({27'h0, irq_n}, 28'h0);
    rv(4'hE, 8'h50);
    chk({27'h0, irq_n}, 28'h0);
    rv(4'h7, 8'h50);
    chk({27'h0, irq_n}, 28'h1);
    atfsc_host_inst.wr(4'hE, 8'h02);
    ev(0);
    @(negedge clk);
    chk({26'h0, irq_n, ien}, 28'h2);
    atfsc_host_inst.wr(4'hE, 8'h00);
    @(negedge clk);
    chk({26'h0, irq_n, ien}, 28'h1);
    rv(4'h7, 8'h50);
    $display("test interrupt done");
    ev(8);
    atfsc_host_inst.wr(4'hE, 8'h04);
    chk({27'h0, srst}, 28'h1);
    rv(4'h7, 8'h80);
    atfsc_host_inst.wr(4'h5, ~cy);
    atfsc_host_inst.wr(4'hF, 8'h00);
    atfsc_host_inst.wr(4'hE, 8'h00);
    repeat (3) @(negedge clk);
    chk({26'h0, srst, busy}, 28'h0);
    rv(4'h5, cy);
    rv(4'h6, dh | 8'hA0);
    $display("test soft reset done");
    end_sim();
  end
endmodule
`default_nettype wire
